// ==== logic/olm_map.svh ====
// olm_map.svh: command codes, addresses, continuity patterns and reset values for the overlay logic
// assumes a 26-bit word address (A25..A0) plus a separate die select bit and a byte-lane bit
`ifndef OLM_MAP_SVH
`define OLM_MAP_SVH
// unlock cycles, compared on the low twelve command address bits
`define OLM_UNL_ADDR1 12'h0555
`define OLM_UNL_ADDR2 12'h02AA
`define OLM_UNL_ADDR1_X8 12'h0AAA
`define OLM_UNL_ADDR2_X8 12'h0555
`define OLM_UNL_DATA1 8'hAA
`define OLM_UNL_DATA2 8'h55
// overlay entry codes, third cycle after the unlock pair
`define OLM_ENT_ECC 8'h75
`define OLM_ENT_PWD 8'h60
`define OLM_ENT_PERS 8'hC0
`define OLM_ENT_LOCK 8'h50
`define OLM_ENT_DYN 8'hE0
// single, two and five cycle commands
`define OLM_CMD_PGM 8'hA0
`define OLM_CMD_EXIT1 8'h90
`define OLM_CMD_EXIT2 8'h00
`define OLM_CMD_RESET 8'hF0
`define OLM_CMD_ERASE1 8'h80
`define OLM_CMD_ERASE2 8'h30
`define OLM_CMD_PWD_UNL 8'h25
`define OLM_CMD_STAT_RD 8'h70
`define OLM_CMD_STAT_CLR 8'h71
// continuity patterns, second write is the bitwise inverse of the first
`define OLM_CC_X16_ADDR1 26'h2AA_AA55
`define OLM_CC_X16_ADDR2 26'h155_55AA
`define OLM_CC_X16_DATA1 16'hFF00
`define OLM_CC_X16_DATA2 16'h00FF
`define OLM_CC_X8_ADDR1 27'h555_54AB
`define OLM_CC_X8_ADDR2 27'h2AA_AB54
`define OLM_CC_X8_DATA1 8'hFF
`define OLM_CC_X8_DATA2 8'h00
// layout
`define OLM_SECT_SHIFT 16
`define OLM_PWD_WORDS 4
`define OLM_PWD_INIT 16'hFFFF
`endif

// ==== logic/olm_pkg.sv ====
// olm_pkg: types shared by the overlay logic and its bench
// assumes nothing beyond a SystemVerilog compiler
package olm_pkg;
	// which address space reads are routed to
	typedef enum logic [2:0] {
		OV_NONE,
		OV_ECC,
		OV_PWD,
		OV_PERS,
		OV_LOCK,
		OV_DYN,
		OV_STATUS
	} olm_mode_t;
	// position inside a multi-cycle command
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_UNL1,
		SEQ_UNL2,
		SEQ_PGM,
		SEQ_EXIT1,
		SEQ_ERASE1,
		SEQ_PWD_UNL
	} olm_seq_t;
endpackage : olm_pkg

// ==== logic/olm_cont_check.sv ====
// olm_cont_check: continuity pattern comparator with its sticky detected flag
// assumes one wr_stb pulse per completed bus write cycle, synchronous to clk
`timescale 1ns/1ps
`include "olm_map.svh"
module olm_cont_check #(
	parameter int ADDR_W = 26,
	parameter bit DUAL_DIE = 1'b0,
	parameter bit DIE_ID = 1'b0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wr_stb,
	input wire logic byte_mode,
	input wire logic die_select_address_bit,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic addr_lsb,
	input wire logic [15:0] wdata,
	input wire logic clear,
	output logic cc_flag
);
	logic armed;
	logic die_hit;
	logic first_hit;
	logic second_hit;
	logic [ADDR_W:0] x8_addr;

	// the die select bit steers the pattern to one die only
	assign die_hit = !DUAL_DIE || (die_select_address_bit == DIE_ID); // see R18
	assign x8_addr = {bus_addr, addr_lsb};
	// full address and data buses are compared, byte mode includes the lane bit
	assign first_hit = byte_mode ?
		(x8_addr == (ADDR_W+1)'(`OLM_CC_X8_ADDR1) && wdata[7:0] == `OLM_CC_X8_DATA1) :
		(bus_addr == ADDR_W'(`OLM_CC_X16_ADDR1) && wdata == `OLM_CC_X16_DATA1); // see R16
	assign second_hit = byte_mode ?
		(x8_addr == (ADDR_W+1)'(`OLM_CC_X8_ADDR2) && wdata[7:0] == `OLM_CC_X8_DATA2) :
		(bus_addr == ADDR_W'(`OLM_CC_X16_ADDR2) && wdata == `OLM_CC_X16_DATA2); // see R16

	// every write re-evaluates, so any other write between the pair drops the match
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			armed <= 1'b0;
		else if (wr_stb)
			armed <= die_hit && first_hit && !cc_flag; // see R23
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cc_flag <= 1'b0;
		else if (wr_stb && armed && die_hit && second_hit)
			cc_flag <= 1'b1; // see R17
		else if (clear)
			cc_flag <= 1'b0; // see R17
	end
endmodule : olm_cont_check

// ==== logic/olm_prot_store.sv ====
// olm_prot_store: per-sector persistent and dynamic protection bits and the global lock bit
// assumes the caller gates updates by overlay mode and lock state
`timescale 1ns/1ps
module olm_prot_store #(
	parameter int SECT_W = 10,
	parameter bit PERS_INIT = 1'b1,
	parameter bit DYN_INIT = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [SECT_W-1:0] sect_idx,
	input wire logic pers_pgm,
	input wire logic pers_erase,
	input wire logic dyn_wr,
	input wire logic dyn_val,
	input wire logic lock_set,
	input wire logic lock_clr,
	output logic persistent_protect_bit,
	output logic dynamic_protect_bit,
	output logic protect_lock_bit
);
	localparam int SECT_N = 1 << SECT_W;
	logic [SECT_N-1:0] pers_vec;
	logic [SECT_N-1:0] dyn_vec;

	// one flop pair per sector; erase of the persistent bits hits all sectors at once
	for (genvar s = 0; s < SECT_N; s++)
	begin : g_sect
		logic pers_q;
		logic dyn_q;
		always_ff @(posedge clk)
		begin
			if (sys_rst)
				pers_q <= PERS_INIT;
			else if (pers_erase)
				pers_q <= 1'b1; // see R7
			else if (pers_pgm && sect_idx == SECT_W'(s))
				pers_q <= 1'b0; // see R7
		end
		always_ff @(posedge clk)
		begin
			if (sys_rst)
				dyn_q <= DYN_INIT;
			else if (dyn_wr && sect_idx == SECT_W'(s))
				dyn_q <= dyn_val; // see R9
		end
		assign pers_vec[s] = pers_q;
		assign dyn_vec[s] = dyn_q;
	end

	// lock set wins over an unlock arriving in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			protect_lock_bit <= 1'b0;
		else if (lock_set)
			protect_lock_bit <= 1'b1; // see R8
		else if (lock_clr)
			protect_lock_bit <= 1'b0; // see R5
	end

	assign persistent_protect_bit = pers_vec[sect_idx];
	assign dynamic_protect_bit = dyn_vec[sect_idx];
endmodule : olm_prot_store

// ==== logic/olm_overlay.sv ====
// olm_overlay: command interpreter for address-space overlays, software reset and continuity check
// assumes one wr_stb per bus write and one rd_stb per completed read, both synchronous to clk;
// the main array and the embedded algorithms sit outside and follow array_sel and alg_busy
`timescale 1ns/1ps
`include "olm_map.svh"
// Functional notes
// R1: overlays are entered only by their entry sequence from normal read mode.
// R2: ecc overlay reads give page ecc enable and corrected-error flags.
// R3: password entry ignores sector address; words zero to three hold the password.
// R4: password words read only when unlocked; written by modified word program.
// R5: password unlock with matching password clears the global lock bit.
// R6: persistent overlay shows sector persistent bit on data bit 0 everywhere in sector.
// R7: modified program clears a persistent bit; erase command resets all of them.
// R8: lock overlay shows the lock bit on data bit 0; modified program sets it.
// R9: dynamic overlay shows sector dynamic bit on bit 0; modified program writes it.
// R10: overlays leave on the legacy two-cycle exit or the common exit command.
// R11: software reset returns controller to standby, exits overlays, clears timeout flag.
// R12: reset commands are ignored while a program or erase runs.
// R13: software reset leaves output driving and algorithm mode alone.
// R14: software reset aborts invalid partial sequences; host uses hardware reset otherwise.
// R15: software reset takes effect in its own write cycle.
// R16: comparator matches two writes with alternating, mutually inverted address and data.
// R17: detected pattern sets status bit zero; status clear command clears it.
// R18: in a dual die package the die select bit steers continuity writes.
// R19: host word-mode continuity sequence uses fixed patterns and status reads.
// R20: host byte-mode continuity sequence uses byte patterns and status read address.
// R21: first read after status read returns status and exits; writes do not exit.
// R22: reads go to overlay contents while any overlay is active.
// R23: only the pair directly after a cleared flag counts; other writes discard it.
module olm_overlay #(
	parameter int ADDR_W = 26,
	parameter bit DUAL_DIE = 1'b0,
	parameter bit DIE_ID = 1'b0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic byte_mode,
	input wire logic die_select_address_bit,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic addr_lsb,
	input wire logic [15:0] wdata,
	input wire logic alg_busy,
	input wire logic wb_abort,
	input wire logic [7:0] status_in,
	input wire logic ecc_page_enabled,
	input wire logic ecc_page_corrected,
	input wire logic password_locked,
	output olm_pkg::olm_mode_t overlay_mode,
	output logic array_sel,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic algorithm_controller_standby,
	output logic timeout_flag_line_clear,
	output logic continuity_detected,
	output logic protect_lock_bit
);
	localparam int SECT_W = ADDR_W - `OLM_SECT_SHIFT;

	olm_pkg::olm_seq_t seq;
	olm_pkg::olm_seq_t next_seq;
	olm_pkg::olm_mode_t next_mode;
	olm_pkg::olm_mode_t prev_mode;
	logic [15:0] password [`OLM_PWD_WORDS];
	logic [15:0] stat_q;
	logic [1:0] pwd_cnt;
	logic pwd_ok;
	logic [11:0] cmd_addr;
	logic [7:0] cmd;
	logic at_unl1;
	logic at_unl2;
	logic pwd_in_range;
	logic [SECT_W-1:0] sect_idx;
	logic do_reset;
	logic enter_status;
	logic stat_clr;
	logic pers_pgm;
	logic pers_erase;
	logic dyn_wr;
	logic lock_set;
	logic lock_clr;
	logic pwd_wr;
	logic pwd_start;
	logic pwd_step;
	logic pers_bit;
	logic dyn_bit;

	// command address: byte mode shifts the lane bit in, so 0xAAA there matches 0x555 here
	assign cmd_addr = byte_mode ? {bus_addr[10:0], addr_lsb} : bus_addr[11:0];
	assign cmd = wdata[7:0];
	assign at_unl1 = cmd_addr == (byte_mode ? `OLM_UNL_ADDR1_X8 : `OLM_UNL_ADDR1);
	assign at_unl2 = cmd_addr == (byte_mode ? `OLM_UNL_ADDR2_X8 : `OLM_UNL_ADDR2);
	// sector index taken from the read or write address itself, never from the entry cycle
	assign sect_idx = bus_addr[ADDR_W-1 -: SECT_W]; // see R6
	assign pwd_in_range = bus_addr[ADDR_W-1:2] == '0; // see R3

	// command decode; the status overlay swallows every write
	always_comb
	begin
		next_mode = overlay_mode;
		next_seq = seq;
		do_reset = 1'b0;
		enter_status = 1'b0;
		stat_clr = 1'b0;
		pers_pgm = 1'b0;
		pers_erase = 1'b0;
		dyn_wr = 1'b0;
		lock_set = 1'b0;
		lock_clr = 1'b0;
		pwd_wr = 1'b0;
		pwd_start = 1'b0;
		pwd_step = 1'b0;
		if (wr_stb && overlay_mode != olm_pkg::OV_STATUS) // see R21
		begin
			if (alg_busy)
			begin
				// only status read is heard while an algorithm runs
				if (seq == olm_pkg::SEQ_IDLE && cmd == `OLM_CMD_STAT_RD && at_unl1)
					enter_status = 1'b1; // see R12
			end
			else if (cmd == `OLM_CMD_RESET && seq != olm_pkg::SEQ_PGM && seq != olm_pkg::SEQ_PWD_UNL)
			begin
				// reset also aborts a half-written sequence, except where a program or password unlock write is due
				do_reset = 1'b1; // see R11
				next_mode = olm_pkg::OV_NONE; // see R10
				next_seq = olm_pkg::SEQ_IDLE; // see R14
			end
			else
			begin
				unique case (seq)
					olm_pkg::SEQ_IDLE:
					begin
						if (cmd == `OLM_CMD_STAT_RD && at_unl1)
							enter_status = 1'b1; // see R21
						else if (cmd == `OLM_CMD_STAT_CLR)
							stat_clr = 1'b1; // see R17
						else if (overlay_mode == olm_pkg::OV_NONE)
						begin
							if (cmd == `OLM_UNL_DATA1 && at_unl1)
								next_seq = olm_pkg::SEQ_UNL1; // see R1
						end
						else if (cmd == `OLM_CMD_EXIT1)
							next_seq = olm_pkg::SEQ_EXIT1; // see R10
						else if (cmd == `OLM_CMD_PGM && overlay_mode != olm_pkg::OV_ECC)
							next_seq = olm_pkg::SEQ_PGM;
						else if (cmd == `OLM_CMD_ERASE1 && overlay_mode == olm_pkg::OV_PERS)
							next_seq = olm_pkg::SEQ_ERASE1;
						else if (cmd == `OLM_CMD_PWD_UNL && overlay_mode == olm_pkg::OV_PWD)
						begin
							next_seq = olm_pkg::SEQ_PWD_UNL;
							pwd_start = 1'b1;
						end
					end
					olm_pkg::SEQ_UNL1:
						next_seq = (cmd == `OLM_UNL_DATA2 && at_unl2) ? olm_pkg::SEQ_UNL2 : olm_pkg::SEQ_IDLE;
					olm_pkg::SEQ_UNL2:
					begin
						// entry code; password and lock entries carry no sector address
						next_seq = olm_pkg::SEQ_IDLE;
						if (at_unl1)
						begin
							if (cmd == `OLM_ENT_ECC)
								next_mode = olm_pkg::OV_ECC; // see R2
							else if (cmd == `OLM_ENT_PWD)
								next_mode = olm_pkg::OV_PWD; // see R3
							else if (cmd == `OLM_ENT_PERS)
								next_mode = olm_pkg::OV_PERS; // see R1
							else if (cmd == `OLM_ENT_LOCK)
								next_mode = olm_pkg::OV_LOCK; // see R1
							else if (cmd == `OLM_ENT_DYN)
								next_mode = olm_pkg::OV_DYN; // see R1
						end
					end
					olm_pkg::SEQ_PGM:
					begin
						// modified word program: address and data of the target
						next_seq = olm_pkg::SEQ_IDLE;
						pers_pgm = overlay_mode == olm_pkg::OV_PERS && !protect_lock_bit; // see R7
						lock_set = overlay_mode == olm_pkg::OV_LOCK; // see R8
						dyn_wr = overlay_mode == olm_pkg::OV_DYN; // see R9
						pwd_wr = overlay_mode == olm_pkg::OV_PWD && pwd_in_range && !password_locked; // see R4
					end
					olm_pkg::SEQ_EXIT1:
					begin
						next_seq = olm_pkg::SEQ_IDLE;
						if (cmd == `OLM_CMD_EXIT2)
							next_mode = olm_pkg::OV_NONE; // see R10
					end
					olm_pkg::SEQ_ERASE1:
					begin
						next_seq = olm_pkg::SEQ_IDLE;
						pers_erase = cmd == `OLM_CMD_ERASE2 && !protect_lock_bit; // see R7
					end
					olm_pkg::SEQ_PWD_UNL:
					begin
						// four password words follow; the last one decides
						pwd_step = 1'b1;
						if (pwd_cnt == 2'd3)
						begin
							next_seq = olm_pkg::SEQ_IDLE;
							lock_clr = pwd_ok && wdata == password[3]; // see R5
						end
					end
				endcase
			end
		end
	end

	// sequence position
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			seq <= olm_pkg::SEQ_IDLE;
		else
			seq <= next_seq;
	end

	// overlay mode changes on the write strobe edge itself, so the next access sees it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			overlay_mode <= olm_pkg::OV_NONE;
		else if (overlay_mode == olm_pkg::OV_STATUS && rd_stb)
			overlay_mode <= prev_mode; // see R21
		else if (enter_status)
			overlay_mode <= olm_pkg::OV_STATUS; // see R21
		else
			overlay_mode <= next_mode; // see R15
	end

	// status capture and the map to return to after the status read
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prev_mode <= olm_pkg::OV_NONE;
			stat_q <= 16'h0000;
		end
		else if (enter_status)
		begin
			prev_mode <= overlay_mode;
			stat_q <= {8'h00, status_in[7:1], continuity_detected};
		end
	end

	// password storage; hardware reset restores the erased value
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < `OLM_PWD_WORDS; i++)
				password[i] <= `OLM_PWD_INIT;
		end
		else if (pwd_wr)
			password[bus_addr[1:0]] <= wdata; // see R4
	end

	// running compare of the supplied password words
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pwd_cnt <= 2'd0;
			pwd_ok <= 1'b0;
		end
		else if (pwd_start)
		begin
			pwd_cnt <= 2'd0;
			pwd_ok <= 1'b1;
		end
		else if (pwd_step)
		begin
			pwd_cnt <= pwd_cnt + 2'd1;
			pwd_ok <= pwd_ok && wdata == password[pwd_cnt]; // see R5
		end
	end

	// one-cycle strobes to the algorithm controller; output driving is not touched here
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			algorithm_controller_standby <= 1'b0;
			timeout_flag_line_clear <= 1'b0;
		end
		else
		begin
			algorithm_controller_standby <= do_reset; // see R11
			timeout_flag_line_clear <= do_reset; // see R11
		end
	end

	// overlay read mux; undefined locations read as zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= rd_stb && overlay_mode != olm_pkg::OV_NONE;
			if (rd_stb)
			begin
				unique case (overlay_mode)
					olm_pkg::OV_NONE:
						rd_data <= 16'h0000;
					olm_pkg::OV_ECC:
						rd_data <= {14'h0000, ecc_page_enabled, ecc_page_corrected}; // see R2
					olm_pkg::OV_PWD:
						rd_data <= (pwd_in_range && !password_locked) ? password[bus_addr[1:0]] : 16'h0000; // see R4
					olm_pkg::OV_PERS:
						rd_data <= {15'h0000, pers_bit}; // see R6
					olm_pkg::OV_LOCK:
						rd_data <= {15'h0000, protect_lock_bit}; // see R8
					olm_pkg::OV_DYN:
						rd_data <= {15'h0000, dyn_bit}; // see R9
					olm_pkg::OV_STATUS:
						rd_data <= stat_q; // see R21
				endcase
			end
		end
	end

	// array serves reads only when no overlay is active
	assign array_sel = overlay_mode == olm_pkg::OV_NONE; // see R22

	olm_prot_store #(
		.SECT_W(SECT_W)
	) u_prot (
		.clk(clk),
		.sys_rst(sys_rst),
		.sect_idx(sect_idx),
		.pers_pgm(pers_pgm),
		.pers_erase(pers_erase),
		.dyn_wr(dyn_wr),
		.dyn_val(wdata[0]),
		.lock_set(lock_set),
		.lock_clr(lock_clr),
		.persistent_protect_bit(pers_bit),
		.dynamic_protect_bit(dyn_bit),
		.protect_lock_bit(protect_lock_bit)
	);

	// soft reset clears the flag only when no buffer abort is pending
	olm_cont_check #(
		.ADDR_W(ADDR_W),
		.DUAL_DIE(DUAL_DIE),
		.DIE_ID(DIE_ID)
	) u_cont (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_stb(wr_stb),
		.byte_mode(byte_mode),
		.die_select_address_bit(die_select_address_bit),
		.bus_addr(bus_addr),
		.addr_lsb(addr_lsb),
		.wdata(wdata),
		.clear(stat_clr || (do_reset && !wb_abort)),
		.cc_flag(continuity_detected)
	);
endmodule : olm_overlay

// ==== testbench/olm_overlay_asserts.sv ====
// olm_overlay_asserts: port-level timing checks for the overlay interpreter
// assumes the olm_overlay port list and a single clk domain with sync reset
`timescale 1ns/1ps
`include "olm_map.svh"
module olm_overlay_asserts #(
	parameter int ADDR_W = 26
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic byte_mode,
	input wire logic [15:0] wdata,
	input wire logic alg_busy,
	input wire olm_pkg::olm_mode_t overlay_mode,
	input wire logic array_sel,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic algorithm_controller_standby,
	input wire logic timeout_flag_line_clear,
	input wire logic continuity_detected,
	input wire logic protect_lock_bit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// command byte, kept as a signal so that $past sees a plain name
	wire logic [7:0] cmd = wdata[7:0];
	a_sel_tracks_mode: assert property (array_sel == (overlay_mode == olm_pkg::OV_NONE))
		else $error("array select disagrees with mode");
	a_stat_first_read: assert property (overlay_mode == olm_pkg::OV_STATUS && rd_stb |=>
		overlay_mode != olm_pkg::OV_STATUS && rd_valid) else $error("status read did not exit");
	a_stat_write_stay: assert property (overlay_mode == olm_pkg::OV_STATUS && !rd_stb |=>
		overlay_mode == olm_pkg::OV_STATUS) else $error("status overlay left without a read");
	a_rdv_has_cause: assert property (rd_valid |-> $past(rd_stb) &&
		$past(overlay_mode) != olm_pkg::OV_NONE) else $error("read valid without overlay read");
	a_reset_same_cycle: assert property (algorithm_controller_standby |-> timeout_flag_line_clear &&
		overlay_mode == olm_pkg::OV_NONE && $past(wr_stb) && $past(cmd) == `OLM_CMD_RESET)
		else $error("standby pulse without soft reset effect");
	a_busy_no_reset: assert property (alg_busy && wr_stb |=> !algorithm_controller_standby)
		else $error("soft reset accepted while busy");
	a_busy_mode_held: assert property (alg_busy && wr_stb && cmd != `OLM_CMD_STAT_RD |=>
		$stable(overlay_mode)) else $error("mode changed while busy");
	a_cc_flag_sticky: assert property (continuity_detected && !wr_stb |=> continuity_detected)
		else $error("continuity flag dropped without a write");
	a_cc_set_cause: assert property ($rose(continuity_detected) |-> $past(wr_stb) &&
		($past(wdata) == `OLM_CC_X16_DATA2 || $past(cmd) == `OLM_CC_X8_DATA2 && $past(byte_mode)))
		else $error("continuity flag set by a wrong write");
	a_lock_on_bit0: assert property (overlay_mode == olm_pkg::OV_LOCK && rd_stb && !wr_stb |=>
		rd_data[0] == protect_lock_bit) else $error("lock read differs from lock bit");
	c_cc_set: cover property ($rose(continuity_detected));
	c_soft_reset: cover property (algorithm_controller_standby);
	c_stat_read: cover property (overlay_mode == olm_pkg::OV_STATUS && rd_stb);
endmodule : olm_overlay_asserts
bind olm_overlay olm_overlay_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .byte_mode(byte_mode), .wdata(wdata), .alg_busy(alg_busy),
	.overlay_mode(overlay_mode), .array_sel(array_sel), .rd_data(rd_data), .rd_valid(rd_valid),
	.algorithm_controller_standby(algorithm_controller_standby),
	.timeout_flag_line_clear(timeout_flag_line_clear),
	.continuity_detected(continuity_detected), .protect_lock_bit(protect_lock_bit));

// ==== testbench/olm_host.sv ====
// olm_host: memory controller model issuing one write or read cycle at a time
// assumes the caller runs cyc serially; byte_mode is set by the bench
`timescale 1ns/1ps
module olm_host #(
	parameter int ADDR_W = 26
) (
	input wire logic clk,
	input wire logic byte_mode,
	output logic wr_stb,
	output logic rd_stb,
	output logic [ADDR_W-1:0] bus_addr,
	output logic addr_lsb,
	output logic [15:0] wdata
);
	// idle bus at time zero
	initial
	begin
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		bus_addr = '0;
		addr_lsb = 1'b0;
		wdata = 16'h0000;
	end
	// one cycle per call; on release bus_addr and wdata show the inverse so stale values never pass
	task automatic cyc(input logic w, input logic [26:0] a, input logic [15:0] d);
		@(negedge clk);
		if (byte_mode)
			{bus_addr, addr_lsb} = a;
		else
		begin
			bus_addr = a[25:0];
			addr_lsb = 1'($urandom);
		end
		wdata = d;
		wr_stb = w;
		rd_stb = !w;
		@(negedge clk);
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		bus_addr = ~bus_addr;
		wdata = ~wdata;
	endtask : cyc
endmodule : olm_host

// ==== testbench/tb.sv ====
// tb: self-checking bench for olm_overlay against a small behavioural model
// assumes olm_host drives the bus; side inputs change at the falling edge
`timescale 1ns/1ps
`include "olm_map.svh"
module tb;
	logic clk, sys_rst, wr_stb, rd_stb, byte_mode, addr_lsb, alg_busy, die_sel, ecc_en, ecc_cor, pwd_lock;
	logic array_sel, rd_valid, standby, tmo_clr, cc_flag, lock_bit;
	logic [25:0] bus_addr;
	logic [15:0] wdata, rd_data, d;
	logic [7:0] status_in;
	olm_pkg::olm_mode_t overlay_mode, em;
	int n_mismatch, tests_run, s;
	// model state
	logic el, ec;
	logic ep[int] = '{default: 1'b1};
	logic ed[int] = '{default: 1'b1};
	logic [15:0] ew[4] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	logic [7:0] codes[5] = '{`OLM_ENT_ECC, `OLM_ENT_PWD, `OLM_ENT_PERS, `OLM_ENT_LOCK, `OLM_ENT_DYN};
	olm_pkg::olm_mode_t modes[5] = '{olm_pkg::OV_ECC, olm_pkg::OV_PWD, olm_pkg::OV_PERS,
		olm_pkg::OV_LOCK, olm_pkg::OV_DYN};
	olm_host u_host (.clk(clk), .byte_mode(byte_mode), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.bus_addr(bus_addr), .addr_lsb(addr_lsb), .wdata(wdata));
	olm_overlay #(.DUAL_DIE(1'b1)) u_dut (.clk(clk), .sys_rst(sys_rst), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.byte_mode(byte_mode), .die_select_address_bit(die_sel), .bus_addr(bus_addr), .addr_lsb(addr_lsb),
		.wdata(wdata), .alg_busy(alg_busy), .wb_abort(1'b0), .status_in(status_in),
		.ecc_page_enabled(ecc_en), .ecc_page_corrected(ecc_cor), .password_locked(pwd_lock),
		.overlay_mode(overlay_mode), .array_sel(array_sel), .rd_data(rd_data), .rd_valid(rd_valid),
		.algorithm_controller_standby(standby), .timeout_flag_line_clear(tmo_clr),
		.continuity_detected(cc_flag), .protect_lock_bit(lock_bit));
	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [26:0] a, input logic [15:0] dd);
		u_host.cyc(1'b1, a, dd);
	endtask : wr
	task automatic rd(input logic [26:0] a, input logic [15:0] exp, input string nm);
		u_host.cyc(1'b0, a, 16'h0000);
		chk(nm, exp, rd_data);
		chk("rd_valid", 16'h0001, 16'(rd_valid));
	endtask : rd
	function automatic logic [26:0] in_sect(input int k);
		return {1'b0, 10'(k), 16'($urandom)};
	endfunction : in_sect
	// entry address carries a random sector, which the interpreter must ignore
	task automatic enter(input int i);
		wr({15'($urandom), 12'h555}, 16'h00AA);
		wr({15'($urandom), 12'h2AA}, 16'h0055);
		wr({15'($urandom), 12'h555}, {8'($urandom), codes[i]});
		em = modes[i];
		chk("mode", 16'(em), 16'(overlay_mode));
	endtask : enter
	task automatic swrst();
		wr(27'($urandom), 16'h00F0);
		chk("standby", 16'h0001, 16'(standby));
		chk("tmo_clr", 16'h0001, 16'(tmo_clr));
		em = olm_pkg::OV_NONE;
		chk("mode", 16'(em), 16'(overlay_mode));
	endtask : swrst
	task automatic pgm(input logic [26:0] a, input logic [15:0] dd);
		wr(27'h0000555, 16'h00A0);
		wr(a, dd);
	endtask : pgm
	// status capture, one ignored write, then the single exiting read
	task automatic stat(input logic [26:0] a);
		status_in = 8'($urandom);
		wr(a, 16'h0070);
		chk("mode", 16'(olm_pkg::OV_STATUS), 16'(overlay_mode));
		wr(27'($urandom), 16'h00F0);
		rd(27'($urandom), {8'h00, status_in[7:1], ec}, "status");
		chk("mode", 16'(em), 16'(overlay_mode));
	endtask : stat
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out();
	end
	// main sequence
	initial
	begin
		void'($urandom(32'h0ca3f062));
		{sys_rst, byte_mode, alg_busy, die_sel, ecc_en, ecc_cor, pwd_lock, status_in} = {1'b1, 6'h00, 8'h00};
		n_mismatch = 0;
		tests_run = 0;
		{el, ec} = 2'b00;
		em = olm_pkg::OV_NONE;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		chk("reset", {10'h000, 3'(em), 1'b1, el, ec}, {10'h000, 3'(overlay_mode), array_sel, lock_bit, cc_flag});
		for (int i = 0; i < 5; i++)
		begin
			enter(i);
			if (i % 2)
				swrst();
			else
			begin
				wr(27'($urandom), 16'h0090);
				wr(27'($urandom), 16'h0000);
				em = olm_pkg::OV_NONE;
				chk("mode", 16'(em), 16'(overlay_mode));
			end
		end
		enter(0);
		repeat (4)
		begin
			{ecc_en, ecc_cor} = 2'($urandom);
			rd(27'($urandom), {14'h0000, ecc_en, ecc_cor}, "ecc");
		end
		swrst();
		// persistent bits: one sector cleared, neighbour untouched, then mass erase
		s = $urandom % 1023;
		enter(2);
		rd(in_sect(s), {15'h0000, ep[s]}, "pers");
		pgm(in_sect(s), 16'h0000);
		ep[s] = 1'b0;
		rd(in_sect(s), {15'h0000, ep[s]}, "pers");
		rd(in_sect(s + 1), {15'h0000, ep[s + 1]}, "pers");
		wr(27'h0000555, 16'h0080);
		wr(27'h0000555, 16'h0030);
		foreach (ep[k]) ep[k] = 1'b1;
		rd(in_sect(s), {15'h0000, ep[s]}, "pers");
		swrst();
		enter(3);
		rd(27'($urandom), {15'h0000, el}, "lock");
		pgm(27'($urandom), 16'h0000);
		el = 1'b1;
		rd(27'($urandom), {15'h0000, el}, "lock");
		swrst();
		// password words, undefined places, locked reads, unlock
		enter(1);
		d = 16'($urandom);
		pgm(27'h0000001, d);
		ew[1] = d;
		rd(27'h0000001, ew[1], "pwd");
		rd(27'h0000005, 16'h0000, "pwd_undef");
		pwd_lock = 1'b1;
		rd(27'h0000001, 16'h0000, "pwd_locked");
		pwd_lock = 1'b0;
		wr(27'h0000555, 16'h0025);
		for (int k = 0; k < 4; k++)
			wr(27'(k), ew[k]);
		el = 1'b0;
		chk("lock", 16'(el), 16'(lock_bit));
		swrst();
		enter(4);
		for (int v = 0; v < 2; v++)
		begin
			pgm(in_sect(s), 16'(v));
			ed[s] = v[0];
			rd(in_sect(s), {15'h0000, ed[s]}, "dyn");
		end
		// busy: reset ignored, status read still served and returns to the overlay
		alg_busy = 1'b1;
		wr(27'($urandom), 16'h00F0);
		chk("standby", 16'h0000, 16'(standby));
		chk("mode", 16'(em), 16'(overlay_mode));
		stat(27'h0000555);
		alg_busy = 1'b0;
		swrst();
		// word-wide continuity pair
		wr(27'h0000555, 16'h0071);
		stat(27'h0000555);
		// pair aimed at the other die must leave this die's flag alone
		die_sel = 1'b1;
		wr(27'(`OLM_CC_X16_ADDR1), `OLM_CC_X16_DATA1);
		wr(27'(`OLM_CC_X16_ADDR2), `OLM_CC_X16_DATA2);
		die_sel = 1'b0;
		chk("cc", 16'(ec), 16'(cc_flag));
		wr(27'(`OLM_CC_X16_ADDR1), `OLM_CC_X16_DATA1);
		wr(27'(`OLM_CC_X16_ADDR2), `OLM_CC_X16_DATA2);
		ec = 1'b1;
		stat(27'h0000555);
		wr(27'($urandom), 16'h0071);
		ec = 1'b0;
		chk("cc", 16'(ec), 16'(cc_flag));
		// byte-wide: an intervening write spoils the pair, a clean pair sets the flag
		byte_mode = 1'b1;
		wr(`OLM_CC_X8_ADDR1, 16'h00FF);
		wr(27'h0000123, 16'h0012);
		wr(`OLM_CC_X8_ADDR2, 16'h0000);
		chk("cc", 16'(ec), 16'(cc_flag));
		wr(`OLM_CC_X8_ADDR1, 16'h00FF);
		wr(`OLM_CC_X8_ADDR2, 16'h0000);
		ec = 1'b1;
		stat(27'h0000AAA);
		byte_mode = 1'b0;
		close_out();
	end
endmodule : tb
